// >>> src/integrator_pkg.sv
// Package with register map, field positions, widths and reset values of the integrator.
package integrator_pkg;
    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] RATE_OFS = 8'h04;
    localparam logic [7:0] DEADBAND_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    localparam logic [7:0] INT_STATUS_OFS = 8'h10;
    localparam logic [7:0] INT_MASK_OFS = 8'h14;
    // Control register field positions.
    localparam int CTRL_BIPOLAR_BIT = 0;
    localparam int CTRL_SP_INV_BIT = 1;
    localparam int CTRL_FB_INV_BIT = 2;
    localparam int CTRL_SUB_BIT = 3;
    // Interrupt status and mask bit positions.
    localparam int INT_W = 3;
    localparam int INT_MIN_BIT = 0;
    localparam int INT_MAX_BIT = 1;
    localparam int INT_OPEN_BIT = 2;
    // Widths.
    localparam int COUNT_W = 12;
    localparam int SAMPLE_W = 12;
    localparam int RATE_W = 16;
    localparam int ERR_W = 14;
    localparam int LEVEL_W = 13;
    localparam int SUM_W = 14;
    // Counter limits and converter scaling shifts.
    localparam logic [COUNT_W-1:0] COUNT_MIN = 12'h000;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 12'hfff;
    localparam logic [COUNT_W-1:0] COUNT_MID = 12'h800;
    localparam int UNI_SHIFT = 12;
    localparam int BI_SHIFT = 11;
    // Reset values of software settings.
    localparam logic [RATE_W-1:0] RATE_RESET = 16'h0040;
    localparam logic [COUNT_W-1:0] DEADBAND_RESET = 12'h010;
endpackage

// >>> src/pin_sync.sv
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous pins and their synchronised copies.
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_s;

    sync_s s_q;
    sync_s s_d;

    // The first stage feeds only the second stage.
    always_comb begin
        s_d.meta = pin_in;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_out = s_q.stable;
endmodule

// >>> src/rate_nco.sv
// Phase accumulator that makes the integration trigger pulse.
`timescale 1ns/100ps
module rate_nco (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Rate setting and trigger pulse.
    input wire logic [integrator_pkg::RATE_W-1:0] rate,
    output logic tick
);
    typedef struct packed {
        logic [integrator_pkg::RATE_W-1:0] phase;
        logic tick;
    } nco_s;

    nco_s s_q;
    nco_s s_d;
    logic [integrator_pkg::RATE_W:0] acc;

    // Tick frequency is proportional to the rate, so zero stops counting.
    always_comb begin
        acc = {1'b0, s_q.phase} + {1'b0, rate};
        s_d.phase = acc[integrator_pkg::RATE_W-1:0];
        s_d.tick = acc[integrator_pkg::RATE_W];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule

// >>> src/digital_integrator_counter.sv
// Up/down counting integrator of a position loop, with APB registers and interrupt.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps

// Function
// - A 12-bit counter holds the integral and drives the converter.
// - Inside the acceptable error window the count is frozen.
// - Four indicators show counting up, counting down, minimum and maximum.
// - Errors inside the symmetric deadband are ignored; beyond it counting starts.
// - A closed reset contact clears the count and forces the indicators, level and combined outputs to zero; irq and APB outputs are not forced.
// - Unipolar mode gives a positive level from zero to the scaled reference.
// - Bipolar mode presets the count to half scale when the contact opens.
// - In bipolar mode counts above midpoint give one polarity, below the other.
// - The rate setting sets the trigger frequency; higher means faster counting.
// - Unipolar step equals the scaled reference divided by 4096.
// - Bipolar step equals the scaled reference divided by 2048.
// - Setpoint and feedback polarity are each invertible by a select.
// - A select adds or subtracts the summing input from the combined result.
// - Error sign sets direction; counting continues while outside the deadband.
module digital_integrator_counter (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog side samples and reset contact.
    input wire logic [integrator_pkg::SAMPLE_W-1:0] setpoint_in,
    input wire logic [integrator_pkg::SAMPLE_W-1:0] feedback_in,
    input wire logic [integrator_pkg::SAMPLE_W-1:0] scaled_integral_level,
    input wire logic [integrator_pkg::SAMPLE_W-1:0] summing_in,
    input wire logic reset_contact,
    // Converter code and results.
    output logic [integrator_pkg::COUNT_W-1:0] dac_count,
    output logic [integrator_pkg::LEVEL_W-1:0] integral_out,
    output logic [integrator_pkg::SUM_W-1:0] combined_out,
    // Indicators and interrupt.
    output logic count_up,
    output logic count_down,
    output logic count_at_min,
    output logic count_at_max,
    output logic irq
);
    localparam int SYNC_W = 4 * integrator_pkg::SAMPLE_W + 1;

    typedef struct packed {
        logic [integrator_pkg::COUNT_W-1:0] count;
        logic signed [integrator_pkg::ERR_W-1:0] err;
        logic signed [integrator_pkg::LEVEL_W-1:0] level;
        logic signed [integrator_pkg::SUM_W-1:0] combined;
        logic up;
        logic down;
        logic at_min;
        logic at_max;
        logic contact_prev;
        logic polarity_mode_select;
        logic setpoint_invert_select;
        logic feedback_invert_select;
        logic sum_sign_select;
        logic [integrator_pkg::RATE_W-1:0] integration_rate_adjust;
        logic [integrator_pkg::COUNT_W-1:0] deadband_adjust;
        logic [integrator_pkg::INT_W-1:0] int_stat;
        logic [integrator_pkg::INT_W-1:0] int_mask;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic [SYNC_W-1:0] sync_out;
    logic tick;

    // Multi-bit samples are assumed to change slowly against pclk; a torn sample
    // only lasts one cycle and the window comparison tolerates it.
    pin_sync #(.W(SYNC_W)) pin_sync_inst (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in({reset_contact, summing_in, scaled_integral_level, feedback_in, setpoint_in}),
        .pin_out(sync_out)
    );

    rate_nco rate_nco_inst (
        .pclk(pclk),
        .presetn(presetn),
        .rate(s_q.integration_rate_adjust),
        .tick(tick)
    );

    logic [integrator_pkg::SAMPLE_W-1:0] sp_s;
    logic [integrator_pkg::SAMPLE_W-1:0] fb_s;
    logic [integrator_pkg::SAMPLE_W-1:0] ref_s;
    logic [integrator_pkg::SAMPLE_W-1:0] sum_s;
    logic contact;
    assign sp_s = sync_out[integrator_pkg::SAMPLE_W-1:0];
    assign fb_s = sync_out[2*integrator_pkg::SAMPLE_W-1:integrator_pkg::SAMPLE_W];
    assign ref_s = sync_out[3*integrator_pkg::SAMPLE_W-1:2*integrator_pkg::SAMPLE_W];
    assign sum_s = sync_out[4*integrator_pkg::SAMPLE_W-1:3*integrator_pkg::SAMPLE_W];
    assign contact = sync_out[SYNC_W-1];

    logic signed [integrator_pkg::ERR_W-1:0] sp_e;
    logic signed [integrator_pkg::ERR_W-1:0] fb_e;
    logic signed [integrator_pkg::ERR_W-1:0] window;
    logic above;
    logic below;
    logic signed [integrator_pkg::LEVEL_W-1:0] centered;
    logic signed [2*integrator_pkg::LEVEL_W-1:0] prod;
    logic [2*integrator_pkg::LEVEL_W-1:0] uprod;
    logic signed [integrator_pkg::SUM_W-1:0] sum_e;
    logic access;
    logic done;
    logic mapped;
    logic [31:0] rdata;
    logic [integrator_pkg::INT_W-1:0] events;

    always_comb begin
        s_d = s_q;
        // Setpoint and feedback are combined with optional inversion of each.
        sp_e = integrator_pkg::ERR_W'($signed(sp_s));
        fb_e = integrator_pkg::ERR_W'($signed(fb_s));
        if (s_q.setpoint_invert_select) begin
            sp_e = -sp_e;
        end
        if (s_q.feedback_invert_select) begin
            fb_e = -fb_e;
        end
        s_d.err = sp_e - fb_e;
        window = $signed({2'b00, s_q.deadband_adjust});
        above = s_q.err > window;
        below = s_q.err < -window;

        // Counter: contact clear, bipolar preset on opening, then rate stepping.
        if (contact) begin
            s_d.count = integrator_pkg::COUNT_MIN;
        end else if (s_q.contact_prev) begin
            s_d.count = s_q.polarity_mode_select ? integrator_pkg::COUNT_MID
                                                 : integrator_pkg::COUNT_MIN;
        end else if (tick) begin
            if (above && s_q.count != integrator_pkg::COUNT_MAX) begin
                s_d.count = s_q.count + 1'b1;
            end else if (below && s_q.count != integrator_pkg::COUNT_MIN) begin
                s_d.count = s_q.count - 1'b1;
            end
            // Inside the window nothing changes, so the count stays frozen.
        end
        s_d.contact_prev = contact;

        // Indicators follow the direction and the limit actually held.
        s_d.up = !contact && above && s_q.count != integrator_pkg::COUNT_MAX;
        s_d.down = !contact && below && s_q.count != integrator_pkg::COUNT_MIN;
        s_d.at_min = !contact && s_d.count == integrator_pkg::COUNT_MIN;
        s_d.at_max = !contact && s_d.count == integrator_pkg::COUNT_MAX;

        // Multiplying converter model: the count ratios the scaled reference.
        centered = $signed({1'b0, s_q.count}) - $signed({1'b0, integrator_pkg::COUNT_MID});
        prod = centered * $signed({1'b0, ref_s});
        uprod = {1'b0, s_q.count} * {1'b0, ref_s};
        if (s_q.polarity_mode_select) begin
            s_d.level = integrator_pkg::LEVEL_W'(prod >>> integrator_pkg::BI_SHIFT);
        end else begin
            s_d.level = integrator_pkg::LEVEL_W'(uprod >> integrator_pkg::UNI_SHIFT);
        end
        sum_e = integrator_pkg::SUM_W'($signed(sum_s));
        if (s_q.sum_sign_select) begin
            s_d.combined = integrator_pkg::SUM_W'(s_q.level) - sum_e;
        end else begin
            s_d.combined = integrator_pkg::SUM_W'(s_q.level) + sum_e;
        end
        if (contact) begin
            s_d.level = '0;
            s_d.combined = '0;
        end

        // APB: one wait state, answer taken at the second access edge.
        access = psel && penable;
        done = access && s_q.pready;
        mapped = 1'b1;
        rdata = '0;
        case (paddr)
            integrator_pkg::CTRL_OFS: begin
                rdata[integrator_pkg::CTRL_BIPOLAR_BIT] = s_q.polarity_mode_select;
                rdata[integrator_pkg::CTRL_SP_INV_BIT] = s_q.setpoint_invert_select;
                rdata[integrator_pkg::CTRL_FB_INV_BIT] = s_q.feedback_invert_select;
                rdata[integrator_pkg::CTRL_SUB_BIT] = s_q.sum_sign_select;
            end
            integrator_pkg::RATE_OFS: begin
                rdata[integrator_pkg::RATE_W-1:0] = s_q.integration_rate_adjust;
            end
            integrator_pkg::DEADBAND_OFS: begin
                rdata[integrator_pkg::COUNT_W-1:0] = s_q.deadband_adjust;
            end
            integrator_pkg::STATUS_OFS: begin
                rdata[integrator_pkg::COUNT_W+3:0] = {s_q.at_max, s_q.at_min, s_q.down, s_q.up,
                                                      s_q.count};
            end
            integrator_pkg::INT_STATUS_OFS: begin
                rdata[integrator_pkg::INT_W-1:0] = s_q.int_stat;
            end
            integrator_pkg::INT_MASK_OFS: begin
                rdata[integrator_pkg::INT_W-1:0] = s_q.int_mask;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        s_d.pready = access && !s_q.pready;
        s_d.pslverr = access && !s_q.pready && !mapped;
        s_d.prdata = (access && !s_q.pready) ? rdata : '0;

        events = '0;
        events[integrator_pkg::INT_MIN_BIT] = s_d.at_min && !s_q.at_min;
        events[integrator_pkg::INT_MAX_BIT] = s_d.at_max && !s_q.at_max;
        events[integrator_pkg::INT_OPEN_BIT] = !contact && s_q.contact_prev;

        if (done && pwrite && mapped) begin
            case (paddr)
                integrator_pkg::CTRL_OFS: begin
                    s_d.polarity_mode_select = pwdata[integrator_pkg::CTRL_BIPOLAR_BIT];
                    s_d.setpoint_invert_select = pwdata[integrator_pkg::CTRL_SP_INV_BIT];
                    s_d.feedback_invert_select = pwdata[integrator_pkg::CTRL_FB_INV_BIT];
                    s_d.sum_sign_select = pwdata[integrator_pkg::CTRL_SUB_BIT];
                end
                integrator_pkg::RATE_OFS: begin
                    s_d.integration_rate_adjust = pwdata[integrator_pkg::RATE_W-1:0];
                end
                integrator_pkg::DEADBAND_OFS: begin
                    s_d.deadband_adjust = pwdata[integrator_pkg::COUNT_W-1:0];
                end
                integrator_pkg::INT_STATUS_OFS: begin
                    s_d.int_stat = s_q.int_stat & ~pwdata[integrator_pkg::INT_W-1:0];
                end
                integrator_pkg::INT_MASK_OFS: begin
                    s_d.int_mask = pwdata[integrator_pkg::INT_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // A new event wins over a clear in the same cycle.
        s_d.int_stat = s_d.int_stat | events;
        s_d.irq = |(s_d.int_stat & s_d.int_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.integration_rate_adjust <= integrator_pkg::RATE_RESET;
            s_q.deadband_adjust <= integrator_pkg::DEADBAND_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign dac_count = s_q.count;
    assign integral_out = s_q.level;
    assign combined_out = s_q.combined;
    assign count_up = s_q.up;
    assign count_down = s_q.down;
    assign count_at_min = s_q.at_min;
    assign count_at_max = s_q.at_max;
    assign irq = s_q.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_saturate_max;
        tick && !contact && !s_q.contact_prev && s_q.count == integrator_pkg::COUNT_MAX
            && above |=> s_q.count == integrator_pkg::COUNT_MAX && s_q.at_max;
    endproperty
    a_saturate_max: assert property (p_saturate_max) else $error("count wrapped at top");

    property p_freeze;
        tick && !contact && !s_q.contact_prev && !above && !below |=> $stable(s_q.count);
    endproperty
    a_freeze: assert property (p_freeze) else $error("count moved inside window");

    property p_step_up;
        tick && !contact && !s_q.contact_prev && above
            && s_q.count != integrator_pkg::COUNT_MAX |=> s_q.count == $past(s_q.count) + 1'b1;
    endproperty
    a_step_up: assert property (p_step_up) else $error("count did not step up");

    property p_contact_clear;
        contact [*2] |=> s_q.count == '0 && s_q.level == '0 && s_q.combined == '0
            && !s_q.up && !s_q.down && !s_q.at_min && !s_q.at_max;
    endproperty
    a_contact_clear: assert property (p_contact_clear) else $error("outputs not zero");

    property p_bipolar_preset;
        $fell(contact) && s_q.polarity_mode_select |=> s_q.count == integrator_pkg::COUNT_MID;
    endproperty
    a_bipolar_preset: assert property (p_bipolar_preset) else $error("no midscale preset");

    property p_bipolar_zero;
        !contact && s_q.polarity_mode_select && s_q.count == integrator_pkg::COUNT_MID
            |=> s_q.level == '0;
    endproperty
    a_bipolar_zero: assert property (p_bipolar_zero) else $error("midscale not zero");

    property p_unipolar_positive;
        !contact && !s_q.polarity_mode_select |=> !s_q.level[integrator_pkg::LEVEL_W-1];
    endproperty
    a_unipolar_positive: assert property (p_unipolar_positive) else $error("neg level");

    property p_indicators;
        !contact && !s_q.contact_prev && tick && below
            && s_q.count != integrator_pkg::COUNT_MIN |=> s_q.down && !s_q.up;
    endproperty
    a_indicators: assert property (p_indicators) else $error("down indicator missing");

    property p_sum_sign;
        !contact && s_q.sum_sign_select && $stable(s_q.sum_sign_select)
            |=> s_q.combined == integrator_pkg::SUM_W'($past(s_q.level))
                - integrator_pkg::SUM_W'($signed($past(sum_s)));
    endproperty
    a_sum_sign: assert property (p_sum_sign) else $error("summing not subtracted");
endmodule

// >>> verification/analog_side_model.sv
// Model of the analog side: error comparator samples, converter reference and reset contact.
`timescale 1ns/100ps
module analog_side_model (
    // Clock.
    input wire logic pclk,
    // Commands from the bench.
    input wire logic [11:0] err_cmd,
    input wire logic [11:0] ref_cmd,
    input wire logic [11:0] sum_cmd,
    input wire logic contact_cmd,
    // Pins of the integrator.
    output logic [11:0] setpoint_in,
    output logic [11:0] feedback_in,
    output logic [11:0] scaled_integral_level,
    output logic [11:0] summing_in,
    output logic reset_contact
);
    // Feedback sits off zero, so an inverted setpoint gives a large error, not a small one.
    localparam logic [11:0] FB_BASE = 12'h100;

    // Samples change once a cycle, like a converter running at the clock rate.
    always @(posedge pclk) begin
        setpoint_in <= FB_BASE + err_cmd;
        feedback_in <= FB_BASE;
        scaled_integral_level <= ref_cmd;
        summing_in <= sum_cmd;
        reset_contact <= contact_cmd;
    end
endmodule

// >>> verification/digital_integrator_counter_test.sv
// Self-checking testbench of the integrator counter.
`timescale 1ns/100ps
module digital_integrator_counter_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, reset_contact, count_up, count_down, count_at_min, count_at_max, irq;
    logic [11:0] err_cmd = 12'h000;
    logic [11:0] sum_cmd = 12'h010;
    logic [11:0] ref_cmd = 12'h800;
    logic contact_cmd = 1'b1;
    logic [11:0] setpoint_in, feedback_in, scaled_integral_level, summing_in, dac_count, c;
    logic [12:0] integral_out;
    logic [13:0] combined_out;
    logic [31:0] rdv;
    logic se;
    int errors = 0;
    int comparisons = 0;
    int d;

    always #5 pclk = ~pclk;

    analog_side_model analog_side_model_inst (.pclk(pclk), .err_cmd(err_cmd),
        .ref_cmd(ref_cmd), .sum_cmd(sum_cmd), .contact_cmd(contact_cmd),
        .setpoint_in(setpoint_in), .feedback_in(feedback_in),
        .scaled_integral_level(scaled_integral_level), .summing_in(summing_in),
        .reset_contact(reset_contact));

    digital_integrator_counter digital_integrator_counter_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .setpoint_in(setpoint_in),
        .feedback_in(feedback_in), .scaled_integral_level(scaled_integral_level),
        .summing_in(summing_in), .reset_contact(reset_contact), .dac_count(dac_count),
        .integral_out(integral_out), .combined_out(combined_out), .count_up(count_up),
        .count_down(count_down), .count_at_min(count_at_min), .count_at_max(count_at_max),
        .irq(irq));

    task automatic complete_run();
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic timeout();
        errors++;
        complete_run();
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; returns one edge after the completing edge.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (pready !== 1'b1) timeout();
        rdv = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(a, 1'b1, wd);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        apb(a, 1'b0, 32'h0);
        chk_reg(rdv, exp);
        chk_pin({15'h0, se}, {15'h0, exp_err});
    endtask

    // The design has no upper bound on how long a count takes, so the wait is capped here.
    task automatic wait_cnt(input logic [11:0] v);
        int n;
        n = 0;
        while (dac_count !== v && n < 6000) begin
            n++;
            @(posedge pclk);
        end
        if (dac_count !== v) timeout();
    endtask

    // Freezes the count, lets the pipeline settle and checks level and sum against the count.
    task automatic level_chk(input logic bip, input logic sub);
        int v;
        err_cmd <= 12'h000;
        repeat (12) @(posedge pclk);
        c = dac_count;
        if (bip) v = ((int'(c) - 2048) * int'(ref_cmd)) >>> 11;
        else v = (int'(c) * int'(ref_cmd)) >> 12;
        chk_pin({3'h0, integral_out}, v[15:0] & 16'h1fff);
        v = sub ? v - 16 : v + 16;
        chk_pin({2'h0, combined_out}, v[15:0] & 16'h3fff);
    endtask

    task automatic all_zero();
        chk_pin({4'h0, dac_count}, 16'h0);
        chk_reg({15'h0, count_up, count_down, count_at_min, count_at_max, integral_out}, 32'h0);
        chk_pin({2'h0, combined_out}, 16'h0);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(integrator_pkg::CTRL_OFS, 32'h0, 1'b0);
        rd_chk(integrator_pkg::RATE_OFS, 32'h40, 1'b0);
        rd_chk(integrator_pkg::DEADBAND_OFS, 32'h10, 1'b0);
        rd_chk(integrator_pkg::INT_MASK_OFS, 32'h0, 1'b0);
        rd_chk(8'h18, 32'h0, 1'b1);
        all_zero();
        wr(integrator_pkg::INT_MASK_OFS, 32'h4);
        wr(integrator_pkg::RATE_OFS, 32'h0);
        contact_cmd <= 1'b0;
        err_cmd <= 12'h040;
        repeat (100) @(posedge pclk);
        chk_pin({4'h0, dac_count}, 16'h0);
        chk_pin({15'h0, count_at_min}, 16'h1);
        chk_pin({15'h0, irq}, 16'h1);
        // Opening the contact in unipolar mode lands on zero, so the minimum event is set too.
        rd_chk(integrator_pkg::INT_STATUS_OFS, 32'h5, 1'b0);
        wr(integrator_pkg::INT_STATUS_OFS, 32'h4);
        chk_pin({15'h0, irq}, 16'h0);
        // A quarter and then half of full rate: 64 and 128 ticks in 256 cycles.
        for (int k = 1; k <= 2; k++) begin
            wr(integrator_pkg::RATE_OFS, 32'h4000 * k);
            repeat (8) @(posedge pclk);
            c = dac_count;
            repeat (256) @(posedge pclk);
            d = int'(dac_count) - int'(c) - 64 * k;
            chk_pin({15'h0, d >= -2 && d <= 2}, 16'h1);
        end
        wr(integrator_pkg::RATE_OFS, 32'hffff);
        wait_cnt(12'h100);
        chk_pin({14'h0, count_up, count_down}, 16'h2);
        // Errors of exactly the deadband on either side must not move the count.
        for (int k = 0; k < 2; k++) begin
            err_cmd <= k ? 12'hff0 : 12'h010;
            repeat (12) @(posedge pclk);
            c = dac_count;
            repeat (100) @(posedge pclk);
            chk_pin({4'h0, dac_count}, {4'h0, c});
        end
        err_cmd <= 12'hfc0;
        wait_cnt(12'h0f0);
        chk_pin({14'h0, count_up, count_down}, 16'h1);
        level_chk(1'b0, 1'b0);
        err_cmd <= 12'h040;
        wait_cnt(12'hfff);
        repeat (50) @(posedge pclk);
        chk_pin({4'h0, dac_count}, 16'h0fff);
        chk_pin({15'h0, count_at_max}, 16'h1);
        chk_pin({15'h0, irq}, 16'h0);
        level_chk(1'b0, 1'b0);
        // A second reference shows that the level really follows the scaling input.
        ref_cmd <= 12'hc00;
        wr(integrator_pkg::CTRL_OFS, 32'h8);
        level_chk(1'b0, 1'b1);
        apb(integrator_pkg::INT_STATUS_OFS, 1'b0, 32'h0);
        chk_reg(rdv & 32'h2, 32'h2);
        wr(integrator_pkg::INT_MASK_OFS, 32'h2);
        chk_pin({15'h0, irq}, 16'h1);
        wr(integrator_pkg::INT_MASK_OFS, 32'h0);
        chk_pin({15'h0, irq}, 16'h0);
        wr(integrator_pkg::CTRL_OFS, 32'h2);
        err_cmd <= 12'h040;
        wait_cnt(12'hf00);
        wr(integrator_pkg::CTRL_OFS, 32'h6);
        err_cmd <= 12'hfc0;
        wait_cnt(12'hf40);
        wr(integrator_pkg::CTRL_OFS, 32'h0);
        wait_cnt(12'h000);
        repeat (20) @(posedge pclk);
        chk_pin({4'h0, dac_count}, 16'h0);
        chk_pin({15'h0, count_at_min}, 16'h1);
        wr(integrator_pkg::CTRL_OFS, 32'h9);
        err_cmd <= 12'h000;
        contact_cmd <= 1'b1;
        repeat (8) @(posedge pclk);
        all_zero();
        contact_cmd <= 1'b0;
        repeat (8) @(posedge pclk);
        chk_pin({4'h0, dac_count}, 16'h0800);
        chk_pin({3'h0, integral_out}, 16'h0);
        err_cmd <= 12'h040;
        wait_cnt(12'h810);
        level_chk(1'b1, 1'b1);
        err_cmd <= 12'hfc0;
        wait_cnt(12'h7e0);
        level_chk(1'b1, 1'b1);
        contact_cmd <= 1'b1;
        repeat (8) @(posedge pclk);
        all_zero();
        complete_run();
    end
endmodule
